// file: include/led_pwm_dimmer_pkg.sv
// constants for the three-channel LED dimming pulse generator
package led_pwm_dimmer_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_NS = 500;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = 4;
  localparam int unsigned PERIOD_TICKS = 95;
  localparam int unsigned RAMP_STEP_MS = 32;
  localparam int unsigned RAMP_STEP_CYCLES = RAMP_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RAMP_CNT_W = 20;
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DUTY_W = 7;
  localparam logic [7:0] ADDR_LED_DIMMER_A = 8'hC6;
  localparam logic [7:0] ADDR_LED_DIMMER_B = 8'hC7;
  localparam logic [7:0] ADDR_LED_DIMMER_C = 8'hC8;
  localparam int unsigned RAMP_ENABLE_BIT = 7;
  localparam int unsigned DUTY_CODE_MSB = 6;
  localparam int unsigned DUTY_CODE_LSB = 0;
  localparam logic [7:0] DIMMER_RESET = 8'h00;
  localparam logic [6:0] DUTY_FULL = 7'h5F;
  localparam logic [6:0] PERIOD_LAST = 7'h5E;
endpackage

// file: logic/led_pwm_dimmer.sv
// three-channel LED dimming pulse generator with optional ramping
`timescale 1ns/1ps
module led_pwm_dimmer #(
  parameter int unsigned RAMP_STEP_CYCLES = led_pwm_dimmer_pkg::RAMP_STEP_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [led_pwm_dimmer_pkg::ADDR_W-1:0] regAddr,
  input wire logic [led_pwm_dimmer_pkg::DATA_W-1:0] regWrData,
  output logic [led_pwm_dimmer_pkg::DATA_W-1:0] regRdData,
  output logic [led_pwm_dimmer_pkg::NUM_CH-1:0] ledOutN
);
  localparam int unsigned NCH = led_pwm_dimmer_pkg::NUM_CH;
  localparam int unsigned DW = led_pwm_dimmer_pkg::DUTY_W;
  localparam int unsigned TW = led_pwm_dimmer_pkg::TICK_CNT_W;
  localparam int unsigned RW = led_pwm_dimmer_pkg::RAMP_CNT_W;
  localparam logic [TW-1:0] TICK_LAST = TW'(led_pwm_dimmer_pkg::TICK_CYCLES - 1);
  localparam logic [RW-1:0] RAMP_LAST = RW'(RAMP_STEP_CYCLES - 1);

  // tick divider
  logic [TW-1:0] tickCnt_ff;
  logic [TW-1:0] nxt_tickCnt;
  logic tickEn;

  // position inside the 95-tick period
  logic [DW-1:0] periodCnt_ff;
  logic [DW-1:0] nxt_periodCnt;
  logic periodEnd;

  // ramp step timer
  logic [RW-1:0] rampCnt_ff;
  logic [RW-1:0] nxt_rampCnt;
  logic rampStrobe;

  // register side
  logic [7:0] regRdData_ff;
  logic [7:0] nxt_regRdData;
  logic [7:0] ctrl [NCH];
  logic [NCH-1:0] wrSel;

  // 0.5 us tick enable from the single clock
  always_comb begin
    tickEn = (tickCnt_ff == TICK_LAST);
    nxt_tickCnt = tickCnt_ff + TW'(1);
    if (tickEn) begin
      nxt_tickCnt = '0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tickCnt_ff <= '0;
    end else begin
      tickCnt_ff <= nxt_tickCnt;
    end
  end

  // period counter, free running so all channels share one boundary
  always_comb begin
    periodEnd = tickEn && (periodCnt_ff == led_pwm_dimmer_pkg::PERIOD_LAST);
    nxt_periodCnt = periodCnt_ff;
    if (periodEnd) begin
      nxt_periodCnt = '0;
    end else if (tickEn) begin
      nxt_periodCnt = periodCnt_ff + DW'(1);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      periodCnt_ff <= '0;
    end else begin
      periodCnt_ff <= nxt_periodCnt;
    end
  end

  // global step timer; the first step after a write may come early
  always_comb begin
    rampStrobe = (rampCnt_ff == RAMP_LAST);
    nxt_rampCnt = rampCnt_ff + RW'(1);
    if (rampStrobe) begin
      nxt_rampCnt = '0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rampCnt_ff <= '0;
    end else begin
      rampCnt_ff <= nxt_rampCnt;
    end
  end

  // write decode, one register per channel at consecutive addresses
  always_comb begin
    wrSel = '0;
    if (!regWrEn) begin
      wrSel = '0;
    end else if (regAddr == led_pwm_dimmer_pkg::ADDR_LED_DIMMER_A) begin
      wrSel[0] = 1'b1;
    end else if (regAddr == led_pwm_dimmer_pkg::ADDR_LED_DIMMER_B) begin
      wrSel[1] = 1'b1;
    end else if (regAddr == led_pwm_dimmer_pkg::ADDR_LED_DIMMER_C) begin
      wrSel[2] = 1'b1;
    end
  end

  // read port, one cycle latency, unmapped addresses read zero
  always_comb begin
    nxt_regRdData = regRdData_ff;
    if (!regRdEn) begin
      nxt_regRdData = regRdData_ff;
    end else if (regAddr == led_pwm_dimmer_pkg::ADDR_LED_DIMMER_A) begin
      nxt_regRdData = ctrl[0];
    end else if (regAddr == led_pwm_dimmer_pkg::ADDR_LED_DIMMER_B) begin
      nxt_regRdData = ctrl[1];
    end else if (regAddr == led_pwm_dimmer_pkg::ADDR_LED_DIMMER_C) begin
      nxt_regRdData = ctrl[2];
    end else begin
      nxt_regRdData = 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdData_ff <= 8'h00;
    end else begin
      regRdData_ff <= nxt_regRdData;
    end
  end

  assign regRdData = regRdData_ff;

  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [DW-1:0] effDuty_ff;
    logic [DW-1:0] nxt_effDuty;
    logic stepPend_ff;
    logic nxt_stepPend;
    logic ledN_ff;
    logic nxt_ledN;
    logic [DW-1:0] target;
    logic rampOn;

    // control register of this channel
    always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wrSel[ch]) begin
        nxt_ctrl = regWrData;
      end
    end

    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        ctrl_ff <= led_pwm_dimmer_pkg::DIMMER_RESET;
      end else begin
        ctrl_ff <= nxt_ctrl;
      end
    end

    // a strobe landing on the boundary stays pending rather than being lost
    always_comb begin
      nxt_stepPend = rampStrobe | (stepPend_ff & ~periodEnd);
    end

    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        stepPend_ff <= 1'b0;
      end else begin
        stepPend_ff <= nxt_stepPend;
      end
    end

    // effective duty, only touched at the boundary so no pulse is cut
    always_comb begin
      rampOn = ctrl_ff[led_pwm_dimmer_pkg::RAMP_ENABLE_BIT];
      target = ctrl_ff[led_pwm_dimmer_pkg::DUTY_CODE_MSB:led_pwm_dimmer_pkg::DUTY_CODE_LSB];
      // codes above full scale all mean 100 percent; ramping past 95 would waste steps
      if (target > led_pwm_dimmer_pkg::DUTY_FULL) begin
        target = led_pwm_dimmer_pkg::DUTY_FULL;
      end
      nxt_effDuty = effDuty_ff;
      if (periodEnd) begin
        if (!rampOn) begin
          nxt_effDuty = target;
        end else if (stepPend_ff && (effDuty_ff < target)) begin
          nxt_effDuty = effDuty_ff + DW'(1);
        end else if (stepPend_ff && (effDuty_ff > target)) begin
          nxt_effDuty = effDuty_ff - DW'(1);
        end
      end
    end

    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        effDuty_ff <= '0;
      end else begin
        effDuty_ff <= nxt_effDuty;
      end
    end

    // low while tick index is below the duty code; code 0 never, >=95 always
    always_comb begin
      nxt_ledN = !(periodCnt_ff < effDuty_ff);
    end

    // registered so the pin never glitches on counter carries
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        ledN_ff <= 1'b1;
      end else begin
        ledN_ff <= nxt_ledN;
      end
    end

    assign ctrl[ch] = ctrl_ff;
    assign ledOutN[ch] = ledN_ff;
  end
endmodule

// file: test/led_load_model.sv
// LED load: on-cycles summed over each 950-cycle window
`timescale 1ns/1ps
module led_load_model (
  input wire logic mclk,
  input wire logic ledN,
  output int onCycles = 0
);
  int win = 0;
  int acc = 0;
  always @(posedge mclk) begin
    acc <= (win == 949) ? 0 : acc + !ledN;
    if (win == 949) onCycles <= acc + !ledN;
    win <= (win == 949) ? 0 : win + 1;
  end
endmodule

// file: test/led_pwm_dimmer_monitor.sv
// port checker for the LED dimmer
`timescale 1ns/1ps
module led_pwm_dimmer_monitor #(parameter int unsigned RAMP_STEP_CYCLES = 2000) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic [2:0] ledOutN
);
  logic [9:0] phase_ff;
  logic [9:0] nxt_phase;
  // slack of two cycles: exact pipeline offset is left to the design
  assign nxt_phase = (phase_ff == 10'h3B5) ? 10'h000 : phase_ff + 10'h001;
  always_ff @(posedge mclk or negedge resetn) phase_ff <= !resetn ? 10'h000 : nxt_phase;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  idle_reset_a: assert property ($rose(resetn) |-> ledOutN == 3'h7)
    else $error("on after reset");
  rd_unmapped_a: assert property (regRdEn && regAddr > 8'hC8
    |=> regRdData == 8'h00) else $error("bad rd");
  rd_back_a: assert property (regWrEn && !regRdEn && regAddr inside {[8'hC6:8'hC8]}
    ##1 regRdEn && !regWrEn && regAddr == $past(regAddr)
    |=> regRdData == $past(regWrData, 2)) else $error("bad back");
  rd_hold_a: assert property (!regRdEn |=> $stable(regRdData)) else $error("rd moved");
  fall_start_a: assert property (|(~ledOutN & $past(ledOutN))
    |-> phase_ff <= 10'h002) else $error("late on");
  rise_tick_a: assert property (|(ledOutN & ~$past(ledOutN))
    |-> phase_ff % 10 <= 2) else $error("off tick");
  low_min_a: assert property ($fell(ledOutN[1]) |=> !ledOutN[1] [*8])
    else $error("short on");
  high_min_a: assert property ($rose(ledOutN[2]) |=> ledOutN[2] [*8])
    else $error("cut off");
  cover property ($fell(ledOutN[0]));
  cover property (ledOutN == 3'h0);
  cover property (regRdEn && regAddr == 8'hC8);
endmodule
bind led_pwm_dimmer led_pwm_dimmer_monitor #(.RAMP_STEP_CYCLES(RAMP_STEP_CYCLES)) led_pwm_dimmer_monitor_i (
  .mclk(mclk), .resetn(resetn), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .ledOutN(ledOutN));

// file: test/led_pwm_dimmer_test.sv
// self-checking bench for the LED dimmer
`timescale 1ns/1ps
module led_pwm_dimmer_test;
  logic mclk = 0, resetn = 0, regWrEn = 0, regRdEn = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [2:0] ledOutN;
  int onCyc [3];
  int failures = 0, samplesChecked = 0;
  led_pwm_dimmer #(.RAMP_STEP_CYCLES(2000)) led_pwm_dimmer_i (.mclk(mclk), .resetn(resetn),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .ledOutN(ledOutN));
  for (genvar i = 0; i < 3; i++) begin : g
    led_load_model led_load_model_i (.mclk(mclk), .ledN(ledOutN[i]), .onCycles(onCyc[i]));
  end
  initial forever #25 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #5 {regWrEn, regRdEn, regAddr, regWrData} = {w, !w, a, d};
    @(posedge mclk);
    #5 {regWrEn, regRdEn} = 2'b00;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #5 {regWrEn, regRdEn, regAddr, regWrData} = {1'b1, 1'b0, a, d};
    @(posedge mclk);
    #5 {regWrEn, regRdEn} = 2'b01;
    @(posedge mclk);
    #5 regRdEn = 1'b0;
  endtask
  task automatic t_regs;
    check(ledOutN, 3'h7);
    for (int i = 0; i < 3; i++) begin
      access(0, 8'hC6 + i, 0);
      check(regRdData, 0);
      access(1, 8'hC6 + i, 8'h5A + i);
    end
    access(1, 8'hC9, 8'hFF);
    access(0, 8'hC9, 0);
    check(regRdData, 0);
    for (int i = 0; i < 3; i++) begin
      access(0, 8'hC6 + i, 0);
      check(regRdData, 8'h5A + i);
    end
    wr_rd(8'hC8, 8'h33);
    check(regRdData, 8'h33);
  endtask
  task automatic t_duty;
    logic [7:0] code [5] = '{8'h00, 8'h01, 8'h02, 8'h5F, 8'h7F};
    int want;
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 3; i++) access(1, 8'hC6 + i, code[(k + i) % 5]);
      // three windows: one full window after the change is settled
      repeat (2900) @(posedge mclk);
      for (int i = 0; i < 3; i++) begin
        want = code[(k + i) % 5] > 95 ? 95 : code[(k + i) % 5];
        check(onCyc[i], want * 10);
      end
    end
  endtask
  task automatic t_ramp;
    access(1, 8'hC7, 8'h8A);
    repeat (2900) @(posedge mclk);
    check(onCyc[1] < 40, 1);
    repeat (24000) @(posedge mclk);
    check(onCyc[1], 100);
    access(1, 8'hC7, 8'h80);
    repeat (2900) @(posedge mclk);
    check(onCyc[1] > 60, 1);
    repeat (24000) @(posedge mclk);
    check(onCyc[1], 0);
  endtask
  task automatic stop_test;
    $display("failures=%0d samplesChecked=%0d", failures, samplesChecked);
    if (failures == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #5 resetn = 1;
    t_regs;
    t_duty;
    t_ramp;
    stop_test;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    stop_test;
  end
endmodule
